// file: test/ssf_failover_manager_tb_top.sv
// Self-checking bench of the stream source failover manager
`timescale 1ns/100ps
module ssf_failover_manager_tb_top;
  import ssf_pkg::*;
  logic sys_clk, rst_n, session_start, teardown, hot_hot_mode, revert_en, opt_wr;
  logic failover_evt, unavail_evt, if_fail_evt, if_redirect_evt, rf_backup_on, rf_fail_evt;
  logic recovery_overrun, rf_backup_evt, sel_ifc, if_all_down;
  logic [31:0] sel_group, sel_source;
  logic active_if, if_fail_idx;
  logic [1:0] opt_wr_idx, sel_idx, if_link_up, if_fail_reason, rf_backup_for;
  logic [3:0] join_mask, opt_pkt, alive, rf_fail, rf_restore, rf_isolate;
  logic [15:0] sid = 16'h5a5a;
  logic [15:0] evt_session;
  logic [31:0] loss = 32'h14;
  int err_total = 0;
  int check_count = 0;

  ssf_failover_manager #(.RECOVERY_CYC(200)) uut (
    .sys_clk, .rst_n, .clk_en(1'h1), .session_start, .teardown, .session_id(sid),
    .hot_hot_mode, .revert_en, .hh_loss_cycles(loss), .hw_loss_cycles(loss), .opt_wr,
    .opt_wr_idx, .opt_wr_group({30'h0, opt_wr_idx}), .opt_wr_source({30'h0, opt_wr_idx}),
    .opt_wr_ifc(opt_wr_idx[0]), .opt_pkt, .join_mask, .sel_idx, .sel_group, .sel_source,
    .sel_ifc, .failover_evt, .unavail_evt, .evt_session, .recovery_overrun,
    .if_link_up, .if_traffic(if_link_up), .if_crit_link_en(1'h1), .if_crit_idle_en(1'h0),
    .if_idle_limit(32'h3e8), .active_if, .if_fail_evt, .if_redirect_evt, .if_fail_idx,
    .if_fail_reason, .if_all_down, .rf_fail, .rf_restore, .rf_isolate, .rf_backup_on,
    .rf_backup_for, .rf_fail_evt, .rf_backup_evt
  );
  ssf_src_model src (.sys_clk, .join_mask, .alive, .opt_pkt);

  // Free-running clock; reset is driven by the main sequence
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Waits a bounded time for one of the event pulses
  task automatic wait_hi(input int w, input int lim);
    for (int n = 0; n < lim; n++) begin
      tick(1);
      if ((w == 0 && failover_evt === 1'h1) || (w == 1 && unavail_evt === 1'h1) ||
          (w == 2 && if_fail_evt === 1'h1) || (w == 3 && rf_fail_evt === 1'h1)) return;
    end
    chk(32'h0, 32'h1, "event timeout");
  endtask

  task automatic wr_opts(input int n);
    @(posedge sys_clk) teardown <= 1'h1;
    for (int i = 0; i < n; i++) @(posedge sys_clk) begin
      teardown <= 1'h0;
      opt_wr <= 1'h1;
      opt_wr_idx <= 2'(i);
    end
    @(posedge sys_clk) opt_wr <= 1'h0;
  endtask

  task automatic start(input logic hh);
    @(posedge sys_clk) begin
      hot_hot_mode <= hh;
      session_start <= 1'h1;
    end
    @(posedge sys_clk) session_start <= 1'h0;
  endtask

  task automatic t_ifc;
    @(posedge sys_clk) if_link_up <= 2'h2;
    wait_hi(2, 10);
    chk({if_redirect_evt, active_if, if_fail_idx, if_fail_reason}, 5'h19, "ifc");
    @(posedge sys_clk) if_link_up <= 2'h0;
    wait_hi(2, 10);
    chk({if_all_down, if_redirect_evt, active_if}, 3'h5, "no spare");
    @(posedge sys_clk) if_link_up <= 2'h3;
    $display("test ifc done");
  endtask

  task automatic t_rf;
    @(posedge sys_clk) rf_fail <= 4'h4;
    wait_hi(3, 5);
    chk({rf_isolate, rf_backup_on, rf_backup_for, rf_backup_evt}, 8'h4d, "rf isolate");
    @(posedge sys_clk) rf_fail <= 4'h0;
    @(posedge sys_clk) rf_restore <= 4'h4;
    @(posedge sys_clk) rf_restore <= 4'h0;
    tick(2);
    chk(rf_isolate, 4'h0, "rf restore");
    $display("test rf done");
  endtask

  task automatic t_hot_warm;
    logic seen0;
    seen0 = 1'h0;
    @(posedge sys_clk) alive <= 4'h2;
    wr_opts(2);
    start(1'h0);
    tick(3);
    chk(join_mask, 4'h1, "hw first join");
    wait_hi(0, 60);
    chk(evt_session, sid, "failover session");
    for (int n = 0; n < 8 && join_mask !== 4'h2; n++) begin
      if (join_mask === 4'h0) seen0 = 1'h1;
      tick(1);
    end
    chk(seen0, 1'h1, "leave before join");
    chk(sel_idx, 2'h1, "next option");
    chk(sel_group, 32'h1, "next group");
    chk({sel_source[30:0], sel_ifc}, 32'h3, "next source");
    @(posedge sys_clk) alive <= 4'h0;
    wait_hi(1, 300);
    chk(join_mask, 4'h0, "leave all");
    tick(205);
    chk(recovery_overrun, 1'h1, "recovery overrun");
    $display("test hot_warm done");
  endtask

  task automatic t_hot_hot;
    @(posedge sys_clk) begin
      alive <= 4'h4;
      revert_en <= 1'h1;
    end
    wr_opts(4);
    start(1'h1);
    tick(3);
    chk(join_mask, 4'hf, "hh join all");
    wait_hi(0, 60);
    tick(4);
    chk(sel_idx, 2'h2, "skip failed");
    @(posedge sys_clk) alive <= 4'hf;
    tick(40);
    chk(sel_idx, 2'h0, "revert");
    chk(recovery_overrun, 1'h0, "recovered in time");
    $display("test hot_hot done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog against a hung design
  initial begin
    #100us;
    err_total++;
    $display("BAD %0t watchdog", $time);
    test_done;
  end

  // Main sequence
  initial begin
    {rst_n, session_start, teardown, hot_hot_mode, revert_en, opt_wr} = 6'h0;
    {opt_wr_idx, alive, rf_fail, rf_restore} = 14'h0;
    if_link_up = 2'h3;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    tick(1);
    chk({join_mask, rf_isolate, failover_evt, unavail_evt, active_if, recovery_overrun}, 12'h0,
        "reset");
    t_ifc;
    t_rf;
    t_hot_warm;
    t_hot_hot;
    test_done;
  end
endmodule // ssf_failover_manager_tb_top

// file: test/ssf_src_model.sv
// Model of the multicast sources feeding the failover manager
`timescale 1ns/100ps
module ssf_src_model (
  input wire logic sys_clk,
  input wire logic [3:0] join_mask,
  input wire logic [3:0] alive,
  output logic [3:0] opt_pkt
);
  logic [1:0] ph_q = 2'h0;
  // A packet every fourth cycle on each group that is joined and live
  always @(posedge sys_clk) begin
    ph_q <= ph_q + 2'h1;
    opt_pkt <= (ph_q == 2'h0) ? (join_mask & alive) : 4'h0;
  end
endmodule // ssf_src_model

// file: verilog/ssf_failover_manager.sv
// Source, input interface and RF output failover manager
`timescale 1ns/100ps
// Notes on behaviour
// - One active input interface, N spares
// - Detect interface failure, redirect on own
// - Interface failure criteria are programmable
// - Report interface failure and redirection events
// - One selected option plus N backups
// - Join group of selected option
// - Several options may share one interface
// - Hot-hot joins all, per-option loss timeout
// - Hot-warm keeps one join only
// - Notification_message failover on each source failure
// - Traffic clears tried; timeout marks selected tried
// - Select highest-ranked untried, mark tried, monitor
// - All tried: unavailable, leave all, wait
// - Hot-warm leaves old group, then joins
// - Hot-hot skips options known failed
// - Hot-hot reverts to higher ranked option
// - Hot-warm required, hot-hot also offered
// - Momentary loss service level at minimum
// - Recovery should finish within one second
// - Detect RF output failure and isolate
// - Switch in backup RF output, report
// - Loss timer starts at join, restarts per packet
module ssf_failover_manager #(
  parameter int OPT_N = ssf_pkg::SSF_OPT_N,
  parameter int IF_N = ssf_pkg::SSF_IF_N,
  parameter int RF_N = ssf_pkg::SSF_RF_N,
  parameter int TMR_W = ssf_pkg::SSF_TMR_W,
  parameter int unsigned RECOVERY_CYC = ssf_pkg::SSF_RECOVERY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic session_start,
  input wire logic teardown,
  input wire logic [ssf_pkg::SSF_SID_W-1:0] session_id,
  input wire logic hot_hot_mode,
  input wire logic revert_en,
  input wire logic [TMR_W-1:0] hh_loss_cycles,
  input wire logic [TMR_W-1:0] hw_loss_cycles,
  input wire logic opt_wr,
  input wire logic [$clog2(OPT_N)-1:0] opt_wr_idx,
  input wire logic [ssf_pkg::SSF_ADDR_W-1:0] opt_wr_group,
  input wire logic [ssf_pkg::SSF_ADDR_W-1:0] opt_wr_source,
  input wire logic [$clog2(IF_N)-1:0] opt_wr_ifc,
  input wire logic [OPT_N-1:0] opt_pkt,
  output logic [OPT_N-1:0] join_mask,
  output logic [$clog2(OPT_N)-1:0] sel_idx,
  output logic [ssf_pkg::SSF_ADDR_W-1:0] sel_group,
  output logic [ssf_pkg::SSF_ADDR_W-1:0] sel_source,
  output logic [$clog2(IF_N)-1:0] sel_ifc,
  output logic failover_evt,
  output logic unavail_evt,
  output logic [ssf_pkg::SSF_SID_W-1:0] evt_session,
  output logic recovery_overrun,
  input wire logic [IF_N-1:0] if_link_up,
  input wire logic [IF_N-1:0] if_traffic,
  input wire logic if_crit_link_en,
  input wire logic if_crit_idle_en,
  input wire logic [TMR_W-1:0] if_idle_limit,
  output logic [$clog2(IF_N)-1:0] active_if,
  output logic if_fail_evt,
  output logic if_redirect_evt,
  output logic [$clog2(IF_N)-1:0] if_fail_idx,
  output logic [1:0] if_fail_reason,
  output logic if_all_down,
  input wire logic [RF_N-1:0] rf_fail,
  input wire logic [RF_N-1:0] rf_restore,
  output logic [RF_N-1:0] rf_isolate,
  output logic rf_backup_on,
  output logic [$clog2(RF_N)-1:0] rf_backup_for,
  output logic rf_fail_evt,
  output logic rf_backup_evt
);
  import ssf_pkg::*;

  localparam int OW = $clog2(OPT_N);
  localparam int IW = $clog2(IF_N);
  localparam int RW = $clog2(RF_N);

  // ----------------------------------------------------------------------
  // Option table and source selection state
  // ----------------------------------------------------------------------
  logic [SSF_ADDR_W-1:0] opt_group_q [OPT_N];
  logic [SSF_ADDR_W-1:0] opt_source_q [OPT_N];
  logic [IW-1:0] opt_ifc_q [OPT_N];
  logic [OPT_N-1:0] opt_valid_q;
  logic [OPT_N-1:0] tried_q;
  logic [OPT_N-1:0] join_q;
  logic [OW-1:0] sel_q;
  logic hot_hot_q;
  logic [SSF_SID_W-1:0] session_q;
  ssf_state_type st_q;
  ssf_state_type st_d;
  logic failover_evt_q;
  logic unavail_evt_q;
  logic [SSF_SID_W-1:0] evt_session_q;
  logic rec_busy_q;
  logic [31:0] rec_cnt_q;
  logic rec_over_q;

  ssf_tmr_if #(.N(OPT_N), .W(TMR_W)) tif ();

  logic [OPT_N-1:0] sel_onehot;
  logic sel_expired;
  logic sel_pkt;
  logic [OPT_N-1:0] cand;
  logic [OW-1:0] cand_idx;
  logic [OPT_N-1:0] revert_vec;
  logic [OW-1:0] revert_idx;
  logic revert_go;

  assign sel_onehot = OPT_N'(1) << sel_q;
  assign sel_expired = tif.expired[sel_q] && join_q[sel_q];
  assign sel_pkt = opt_pkt[sel_q] && join_q[sel_q];
  // Hot-hot already knows which options died and skips them
  assign cand = opt_valid_q & ~tried_q & (hot_hot_q ? ~tif.expired : '1);
  assign cand_idx = OW'(ssf_first(32'(cand)));
  // Higher ranked joined options with fresh traffic
  assign revert_vec = opt_pkt & join_q & ~tif.expired & (sel_onehot - OPT_N'(1));
  assign revert_idx = OW'(ssf_first(32'(revert_vec)));
  assign revert_go = hot_hot_q && revert_en && (|revert_vec);

  // Timers run on every joined option; restart on join and per packet
  assign tif.arm = join_q;
  assign tif.restart = opt_pkt | ((st_q == ST_JOIN) ? join_q : '0);
  assign tif.limit = hot_hot_q ? hh_loss_cycles : hw_loss_cycles;

  ssf_loss_timer_bank #(.N(OPT_N), .W(TMR_W)) u_timers (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .tif(tif)
  );

  // Option table written by the resource manager side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < OPT_N; i++) begin
        opt_group_q[i] <= '0;
        opt_source_q[i] <= '0;
        opt_ifc_q[i] <= '0;
      end
      opt_valid_q <= '0;
    end else if (clk_en) begin
      if (teardown) begin
        opt_valid_q <= '0;
      end else if (opt_wr) begin
        opt_group_q[opt_wr_idx] <= opt_wr_group;
        opt_source_q[opt_wr_idx] <= opt_wr_source;
        opt_ifc_q[opt_wr_idx] <= opt_wr_ifc;
        opt_valid_q[opt_wr_idx] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Failover sequence
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (teardown) begin
      st_d = ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (session_start && (|opt_valid_q)) begin
            st_d = ST_JOIN;
          end
        end
        ST_MONITOR: begin
          if (sel_expired) begin
            st_d = ST_NOTIFICATION_MESSAGE;
          end
        end
        ST_NOTIFICATION_MESSAGE: st_d = ST_SELECT;
        ST_SELECT: begin
          if (|cand) begin
            st_d = hot_hot_q ? ST_MONITOR : ST_LEAVE;
          end else begin
            st_d = ST_EXHAUST;
          end
        end
        ST_LEAVE: st_d = ST_JOIN;
        ST_JOIN: st_d = ST_MONITOR;
        ST_EXHAUST: st_d = ST_WAIT_TEAR;
        ST_WAIT_TEAR: st_d = ST_WAIT_TEAR;
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // State register and per-session mode capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      hot_hot_q <= 1'b0;
      session_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      if (st_q == ST_IDLE && session_start) begin
        hot_hot_q <= hot_hot_mode;
        session_q <= session_id;
      end
    end
  end

  // Selected option
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= '0;
    end else if (clk_en) begin
      if (st_q == ST_IDLE && session_start) begin
        sel_q <= OW'(ssf_first(32'(opt_valid_q)));
      end else if (st_q == ST_SELECT && (|cand)) begin
        sel_q <= cand_idx;
      end else if (st_q == ST_MONITOR && !sel_expired && revert_go) begin
        sel_q <= revert_idx;
      end
    end
  end

  // Tried marks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tried_q <= '0;
    end else if (clk_en) begin
      if (teardown || (st_q == ST_IDLE && session_start)) begin
        tried_q <= '0;
      end else if (st_q == ST_MONITOR && sel_expired) begin
        tried_q[sel_q] <= 1'b1;
      end else if (st_q == ST_MONITOR && sel_pkt) begin
        tried_q <= '0;
      end else if (st_q == ST_SELECT && (|cand)) begin
        tried_q[cand_idx] <= 1'b1;
      end
    end
  end

  // Multicast joins: all in hot-hot, one in hot-warm
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      join_q <= '0;
    end else if (clk_en) begin
      if (teardown) begin
        join_q <= '0;
      end else begin
        case (st_q)
          ST_JOIN: join_q <= hot_hot_q ? opt_valid_q : sel_onehot;
          ST_LEAVE: join_q <= '0;
          ST_EXHAUST: join_q <= '0;
          default: join_q <= join_q;
        endcase
      end
    end
  end

  // Notification pulses toward the message generator
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      failover_evt_q <= 1'b0;
      unavail_evt_q <= 1'b0;
      evt_session_q <= '0;
    end else if (clk_en) begin
      failover_evt_q <= (st_q == ST_NOTIFICATION_MESSAGE);
      unavail_evt_q <= (st_q == ST_EXHAUST);
      if (st_q == ST_NOTIFICATION_MESSAGE || st_q == ST_EXHAUST) begin
        evt_session_q <= session_q;
      end
    end
  end

  // Recovery watch: momentary loss is tolerated, overrun is flagged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_busy_q <= 1'b0;
      rec_cnt_q <= '0;
      rec_over_q <= 1'b0;
    end else if (clk_en) begin
      if (teardown || (st_q == ST_IDLE && session_start)) begin
        rec_busy_q <= 1'b0;
        rec_over_q <= 1'b0;
      end else if (st_q == ST_NOTIFICATION_MESSAGE) begin
        rec_busy_q <= 1'b1;
        rec_cnt_q <= '0;
      end else if (rec_busy_q && st_q == ST_MONITOR && sel_pkt) begin
        rec_busy_q <= 1'b0;
      end else if (rec_busy_q && rec_cnt_q < RECOVERY_CYC) begin
        rec_cnt_q <= rec_cnt_q + 32'h1;
      end else if (rec_busy_q) begin
        rec_over_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input interface redundancy
  // ----------------------------------------------------------------------
  logic [IW-1:0] act_q;
  logic [IF_N-1:0] if_failed_q;
  logic [TMR_W-1:0] if_idle_q;
  logic if_fail_evt_q;
  logic if_redir_evt_q;
  logic [IW-1:0] if_fail_idx_q;
  logic [1:0] if_reason_q;
  logic if_all_down_q;
  logic if_link_bad;
  logic if_idle_bad;
  logic if_det;
  logic [IF_N-1:0] if_spare;
  logic if_move;

  assign if_link_bad = if_crit_link_en && !if_link_up[act_q];
  assign if_idle_bad = if_crit_idle_en && (if_idle_q >= if_idle_limit);
  assign if_det = (if_link_bad || if_idle_bad) && !if_failed_q[act_q];
  assign if_spare = if_link_up & ~if_failed_q & ~(IF_N'(1) << act_q);
  assign if_move = (if_det || if_failed_q[act_q]) && (|if_spare);

  // Active interface choice and failed marks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= '0;
      if_failed_q <= '0;
      if_idle_q <= '0;
      if_all_down_q <= 1'b0;
    end else if (clk_en) begin
      for (int i = 0; i < IF_N; i++) begin
        if (if_det && act_q == IW'(i)) begin
          if_failed_q[i] <= 1'b1;
        end else if (if_traffic[i] && if_link_up[i]) begin
          if_failed_q[i] <= 1'b0;
        end
      end
      if (if_move) begin
        act_q <= IW'(ssf_first(32'(if_spare)));
        if_idle_q <= '0;
        if_all_down_q <= 1'b0;
      end else if (if_det) begin
        if_all_down_q <= 1'b1;
      end else if (if_traffic[act_q]) begin
        if_idle_q <= '0;
        if_all_down_q <= 1'b0;
      end else if (if_idle_q < if_idle_limit) begin
        if_idle_q <= if_idle_q + TMR_W'(1);
      end
    end
  end

  // Interface failure and redirection reports
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      if_fail_evt_q <= 1'b0;
      if_redir_evt_q <= 1'b0;
      if_fail_idx_q <= '0;
      if_reason_q <= SSF_IFC_OK;
    end else if (clk_en) begin
      if_fail_evt_q <= if_det;
      if_redir_evt_q <= if_move;
      if (if_det) begin
        if_fail_idx_q <= act_q;
        if_reason_q <= if_link_bad ? SSF_IFC_FAIL_LINK : SSF_IFC_FAIL_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // RF output redundancy
  // ----------------------------------------------------------------------
  logic [RF_N-1:0] rf_iso_q;
  logic rf_bk_on_q;
  logic [RW-1:0] rf_bk_for_q;
  logic rf_fail_evt_q;
  logic rf_bk_evt_q;
  logic [RF_N-1:0] rf_new;
  logic rf_bk_free;

  assign rf_new = rf_fail & ~rf_iso_q;
  assign rf_bk_free = !rf_bk_on_q || (rf_restore[rf_bk_for_q] && !rf_fail[rf_bk_for_q]);

  // Isolation marks: a failure wins over a restore in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_iso_q <= '0;
    end else if (clk_en) begin
      rf_iso_q <= rf_fail | (rf_iso_q & ~rf_restore);
    end
  end

  // Backup output takes over the first failed output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_bk_on_q <= 1'b0;
      rf_bk_for_q <= '0;
      rf_fail_evt_q <= 1'b0;
      rf_bk_evt_q <= 1'b0;
    end else if (clk_en) begin
      rf_fail_evt_q <= |rf_new;
      rf_bk_evt_q <= 1'b0;
      if (rf_bk_free && (|rf_new)) begin
        rf_bk_on_q <= 1'b1;
        rf_bk_for_q <= RW'(ssf_first(32'(rf_new)));
        rf_bk_evt_q <= 1'b1;
      end else if (rf_bk_free) begin
        rf_bk_on_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign join_mask = join_q;
  assign sel_idx = sel_q;
  assign sel_group = opt_group_q[sel_q];
  assign sel_source = opt_source_q[sel_q];
  assign sel_ifc = opt_ifc_q[sel_q];
  assign failover_evt = failover_evt_q;
  assign unavail_evt = unavail_evt_q;
  assign evt_session = evt_session_q;
  assign recovery_overrun = rec_over_q;
  assign active_if = act_q;
  assign if_fail_evt = if_fail_evt_q;
  assign if_redirect_evt = if_redir_evt_q;
  assign if_fail_idx = if_fail_idx_q;
  assign if_fail_reason = if_reason_q;
  assign if_all_down = if_all_down_q;
  assign rf_isolate = rf_iso_q;
  assign rf_backup_on = rf_bk_on_q;
  assign rf_backup_for = rf_bk_for_q;
  assign rf_fail_evt = rf_fail_evt_q;
  assign rf_backup_evt = rf_bk_evt_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence s_timeout;
    st_q == ST_MONITOR && sel_expired && !teardown;
  endsequence
  sequence s_notification_message;
    st_q == ST_NOTIFICATION_MESSAGE && !teardown;
  endsequence

  property p_timeout_tried;
    s_timeout |=> (st_q == ST_NOTIFICATION_MESSAGE && tried_q[$past(sel_q)]);
  endproperty
  a_timeout_tried: assert property (p_timeout_tried) else $error("timeout not handled");

  property p_notification_message_pulse;
    s_notification_message |=> (failover_evt && evt_session == session_q) ##1 !failover_evt;
  endproperty
  a_notification_message_pulse: assert property (p_notification_message_pulse) else $error("bad failover pulse");

  property p_traffic_clears;
    (st_q == ST_MONITOR && sel_pkt && !sel_expired && !teardown) |=> tried_q == '0;
  endproperty
  a_traffic_clears: assert property (p_traffic_clears) else $error("tried not cleared");

  property p_select_lowest;
    (st_q == ST_SELECT && (|cand) && !teardown) |=> (sel_q == $past(cand_idx) && tried_q[sel_q]);
  endproperty
  a_select_lowest: assert property (p_select_lowest) else $error("wrong option chosen");

  property p_leave_then_join;
    (st_q == ST_LEAVE && !teardown) |=> (join_q == '0 && st_q == ST_JOIN) ##1
      (join_q == sel_onehot && st_q == ST_MONITOR);
  endproperty
  a_leave_then_join: assert property (p_leave_then_join) else $error("leave/join order");

  property p_hw_single;
    !hot_hot_q |-> $countones(join_q) <= 1;
  endproperty
  a_hw_single: assert property (p_hw_single) else $error("hot-warm multi join");

  property p_exhaust;
    (st_q == ST_EXHAUST && !teardown) |=> (unavail_evt && join_q == '0 && st_q == ST_WAIT_TEAR);
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("exhaust handling");

  property p_if_redirect;
    if_move |=> (if_redirect_evt && active_if != $past(act_q) && !if_failed_q[active_if]);
  endproperty
  a_if_redirect: assert property (p_if_redirect) else $error("no redirect");

  property p_rf_isolate;
    (|rf_new) |=> ((rf_isolate & $past(rf_fail)) == $past(rf_fail) && rf_fail_evt);
  endproperty
  a_rf_isolate: assert property (p_rf_isolate) else $error("rf not isolated");

endmodule // ssf_failover_manager

// file: verilog/ssf_loss_timer_bank.sv
// Per-option multicast session loss timers
`timescale 1ns/100ps
module ssf_loss_timer_bank #(
  parameter int N = ssf_pkg::SSF_OPT_N,
  parameter int W = ssf_pkg::SSF_TMR_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  ssf_tmr_if.bank tif
);
  import ssf_pkg::*;

  logic [W-1:0] cnt_q [N];
  logic [N-1:0] expired_q;

  // ----------------------------------------------------------------------
  // Counters: idle while not joined, restart on join or packet
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        cnt_q[i] <= '0;
      end
      expired_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N; i++) begin
        if (!tif.arm[i] || tif.restart[i]) begin
          cnt_q[i] <= '0;
          expired_q[i] <= 1'b0;
        end else if (cnt_q[i] >= tif.limit) begin
          expired_q[i] <= 1'b1;
        end else begin
          cnt_q[i] <= cnt_q[i] + W'(1);
        end
      end
    end
  end

  assign tif.expired = expired_q;

  // Restart always returns the counter to zero
  property p_tmr_restart;
    @(posedge sys_clk) disable iff (!rst_n || !clk_en)
      tif.restart[0] |=> (cnt_q[0] == '0 && !expired_q[0]);
  endproperty
  a_tmr_restart: assert property (p_tmr_restart) else $error("timer not restarted");

endmodule // ssf_loss_timer_bank

// file: verilog/ssf_pkg.sv
// Shared constants, types and helpers of the stream source failover manager
package ssf_pkg;

  // ----------------------------------------------------------------------
  // Clock and recovery timing
  // ----------------------------------------------------------------------
  localparam int unsigned SSF_CLK_HZ = 50_000_000;
  localparam int unsigned SSF_MS_PER_S = 1000;
  localparam int unsigned SSF_RECOVERY_MS = 1000;
  // Longest time, so the division rounds down
  localparam int unsigned SSF_RECOVERY_CYC = SSF_CLK_HZ / SSF_MS_PER_S * SSF_RECOVERY_MS;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int SSF_OPT_N = 4;
  localparam int SSF_IF_N = 2;
  localparam int SSF_RF_N = 4;
  localparam int SSF_TMR_W = 32;
  localparam int SSF_ADDR_W = 32;
  localparam int SSF_SID_W = 16;
  localparam int SSF_IDX_W = 5;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [SSF_IDX_W-1:0] SSF_IDX_RST = 5'h00;
  localparam logic [1:0] SSF_IFC_OK = 2'h0;
  localparam logic [1:0] SSF_IFC_FAIL_LINK = 2'h1;
  localparam logic [1:0] SSF_IFC_FAIL_IDLE = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_MONITOR   = 3'b001,
    ST_NOTIFICATION_MESSAGE  = 3'b010,
    ST_SELECT    = 3'b011,
    ST_LEAVE     = 3'b100,
    ST_JOIN      = 3'b101,
    ST_EXHAUST   = 3'b110,
    ST_WAIT_TEAR = 3'b111
  } ssf_state_type;

  // Index of the lowest set bit; zero when none is set
  function automatic logic [SSF_IDX_W-1:0] ssf_first(input logic [31:0] v);
    logic [SSF_IDX_W-1:0] r;
    r = SSF_IDX_RST;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = SSF_IDX_W'(i);
      end
    end
    return r;
  endfunction

endpackage

// file: verilog/ssf_tmr_if.sv
// Link between the failover manager and its session loss timer bank
`timescale 1ns/100ps
interface ssf_tmr_if #(
  parameter int N = 4,
  parameter int W = 32
);
  logic [N-1:0] arm;
  logic [N-1:0] restart;
  logic [W-1:0] limit;
  logic [N-1:0] expired;

  modport mgr (output arm, output restart, output limit, input expired);
  modport bank (input arm, input restart, input limit, output expired);
endinterface
